// ===== inc/lsd_map.svh
/*
  Constants of the seven-to-one link receiver: lane counts, word layout and timing counts.
  Assumes a 100 MHz system clock; included by its bare name.
*/
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH
`define LSD_LANES 4
`define LSD_BITS 7
`define LSD_WORD 28
`define LSD_LINE_SYNC_BIT 24
`define LSD_FRAME_SYNC_BIT 25
`define LSD_PIXEL_VALID_BIT 26
`define LSD_SPARE_BIT 27
`define LSD_CLK_MHZ 100
`define LSD_LOCK_TIME_MS 10
`define LSD_LOCK_CYC (`LSD_LOCK_TIME_MS * 1000 * `LSD_CLK_MHZ)
`define LSD_SLEEP_ENTRY_DELAY_NS 1000
`define LSD_SLEEP_ENTRY_CYC ((`LSD_SLEEP_ENTRY_DELAY_NS * `LSD_CLK_MHZ) / 1000)
`define LSD_LOCK_EDGES 4
`define LSD_PHASE_W 8
`define LSD_WORD_RESET 28'h000_0000
`endif

// ===== inc/lsd_pkg.sv
/*
  Types of the seven-to-one link receiver.
  Assumes nothing beyond the map header for numbers.
*/
package lsd_pkg;
  typedef enum logic [2:0]
  {
    lsd_st_sleep = 3'b001,
    lsd_st_acquire = 3'b010,
    lsd_st_locked = 3'b100
  } lsd_state_e;
endpackage : lsd_pkg

// ===== rtl/lsd_buffer.sv
/*
  Two-entry word buffer with valid and ready on both sides; entries are registers.
  Assumes a single clock and a synchronous active-high clear.
*/
`timescale 1ns/1ns
`default_nettype none
module lsd_buffer #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2
) (
  // Clock and clear
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  initial
  begin
    if (DEPTH != 2)
      $error("lsd_buffer supports exactly two entries");
  end

  logic [WIDTH-1:0] mem [0:1];
  logic wptr;
  logic rptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rptr];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (push)
        wptr <= ~wptr;
      if (pop)
        rptr <= ~rptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end
endmodule : lsd_buffer
`default_nettype wire

// ===== rtl/lsd_receiver.sv
/*
  Receive side of a seven-to-one serial display link: samples four lanes seven times per
  link-clock period and presents a 28-bit word strobed by the falling edge of an output clock.
  Assumes the link clock and lanes are asynchronous to sys_clk and far slower than it.
*/
// Overview of operation
// (R1) Four serial data lanes plus one forwarded link clock arrive at the receiver.
// (R2) Seven bits per lane per link period, strobes evenly spaced at one seventh period.
// (R3) Recovered bits form a 28-bit word: 24 colour bits plus sync and enable lines.
// (R4) Output pixel clock falling edge strobes the word; word changes only at rising edge.
// (R5) Output pixel clock follows the link clock at the same rate.
// (R6) Lock is reached well within 10 ms of a valid clock; outputs invalid before that.
// (R7) While sleep_n is low, every parallel output is forced low.
// (R8) Sleep state is entered within 1 microsecond of sleep_n falling.
// (R9) Lane bit k of lane l appears on word bit l*7+k, matching the transmitter.
`timescale 1ns/1ns
`default_nettype none
`include "lsd_map.svh"
module lsd_receiver #(
  parameter int LANES = `LSD_LANES,
  parameter int BITS = `LSD_BITS,
  parameter int LOCK_EDGES = `LSD_LOCK_EDGES,
  parameter int LOCK_CYC = `LSD_LOCK_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link
  input wire logic [LANES-1:0] serial_lane_in,
  input wire logic link_clock_in,
  // Power control
  input wire logic sleep_n,
  // Panel side
  input wire logic panel_ready,
  output logic [LANES*BITS-1:0] parallel_word_out,
  output logic pixel_strobe_out,
  // Status
  output logic link_locked,
  output logic word_overrun
);
  localparam int WORD = LANES * BITS;
  localparam int PW = `LSD_PHASE_W;

  initial
  begin
    if (WORD != `LSD_WORD || LOCK_EDGES < 1 || LOCK_EDGES > 15 || LOCK_CYC < 1)
      $error("lsd_receiver parameters out of range");
  end

  // Two flip-flops on everything arriving from outside the clock domain.
  logic [LANES-1:0] lane_s1;
  logic [LANES-1:0] lane_s2;
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic sleep_s1;
  logic sleep_s2;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lane_s1 <= '0;
      lane_s2 <= '0;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end
    else
    begin
      lane_s1 <= serial_lane_in; // R1
      lane_s2 <= lane_s1;
      clk_s1 <= link_clock_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      sleep_s1 <= sleep_n;
      sleep_s2 <= sleep_s1;
    end
  end

  wire asleep = ~sleep_s2;
  wire link_rise = clk_s2 && !clk_s3;

  // Position of this cycle inside the link period and the period last measured.
  logic [PW-1:0] phase;
  logic [PW-1:0] period;
  logic [BITS-1:0] taken;
  logic [WORD-1:0] shift_word;
  wire [PW-1:0] pos = link_rise ? '0 : phase + ((phase == {PW{1'b1}}) ? PW'(0) : PW'(1));
  wire [PW+4-1:0] pos_x7 = (PW+4)'(pos) * (PW+4)'(7);
  wire clock_lost = (phase == {PW{1'b1}});
  logic [BITS-1:0] next_take;
  wire [WORD-1:0] next_shift;

  // Strobe k takes the first sample at or after k/7 of the measured period, bit 0 on the rise itself.
  // With only about eight samples per period a centred strobe would miss the last bit, so margin is traded.
  genvar k;
  generate
    for (k = 0; k < BITS; k++)
    begin : g_strobe
      wire [PW+4-1:0] thr = (PW+4)'(period) * (PW+4)'(k);
      assign next_take[k] = (link_rise || !taken[k]) && (pos_x7 >= thr); // R2
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst || asleep)
    begin
      phase <= {PW{1'b1}};
      period <= '0;
      taken <= '0;
    end
    else
    begin
      phase <= pos;
      if (link_rise)
        period <= phase + PW'(1); // R5
      taken <= link_rise ? next_take : (taken | next_take);
    end
  end

  generate
    for (k = 0; k < BITS; k++)
    begin : g_capture
      genvar l;
      for (l = 0; l < LANES; l++)
      begin : g_lane
        assign next_shift[l * BITS + k] = next_take[k] ? lane_s2[l] : shift_word[l * BITS + k]; // R9
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      shift_word <= '0;
    else
      shift_word <= next_shift;
  end

  // Lock tracking.
  lsd_pkg::lsd_state_e state;
  lsd_pkg::lsd_state_e next_state;
  logic [3:0] edge_cnt;
  wire enough_edges = (edge_cnt >= 4'(LOCK_EDGES));

  always_comb
  begin
    case (state)
      lsd_pkg::lsd_st_sleep: next_state = asleep ? lsd_pkg::lsd_st_sleep : lsd_pkg::lsd_st_acquire;
      lsd_pkg::lsd_st_acquire: next_state = enough_edges ? lsd_pkg::lsd_st_locked : lsd_pkg::lsd_st_acquire;
      lsd_pkg::lsd_st_locked: next_state = clock_lost ? lsd_pkg::lsd_st_acquire : lsd_pkg::lsd_st_locked;
      default: next_state = lsd_pkg::lsd_st_sleep;
    endcase
    if (asleep)
      next_state = lsd_pkg::lsd_st_sleep; // R8
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= lsd_pkg::lsd_st_sleep;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || state != lsd_pkg::lsd_st_acquire || clock_lost)
      edge_cnt <= '0;
    else if (link_rise && !enough_edges)
      edge_cnt <= edge_cnt + 4'h1; // R6
  end

  wire locked = (state == lsd_pkg::lsd_st_locked);
  assign link_locked = locked;

  // A finished word waits here until the buffer takes it; a later word is dropped meanwhile.
  logic pend_valid;
  logic [WORD-1:0] pend_word;
  wire buf_in_ready;
  wire word_done = locked && link_rise && (&taken);
  wire pend_take = pend_valid && buf_in_ready;

  always_ff @(posedge sys_clk)
  begin
    if (rst || asleep)
    begin
      pend_valid <= 1'b0;
      pend_word <= `LSD_WORD_RESET;
      word_overrun <= 1'b0;
    end
    else
    begin
      word_overrun <= word_done && pend_valid && !pend_take;
      if (word_done && (!pend_valid || pend_take))
      begin
        pend_valid <= 1'b1;
        pend_word <= shift_word; // R3
      end
      else if (pend_take)
        pend_valid <= 1'b0;
    end
  end

  wire buf_out_valid;
  wire [WORD-1:0] buf_out_data;
  wire strobe_rise = clk_s2 && !pixel_strobe_out;
  wire buf_pop = strobe_rise && panel_ready && locked;

  lsd_buffer #(
    .WIDTH(WORD),
    .DEPTH(2)
  ) i_lsd_buffer (
    .sys_clk(sys_clk),
    .rst(rst || asleep),
    .in_valid(pend_valid),
    .in_ready(buf_in_ready),
    .in_data(pend_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // The word is loaded on the output clock's rising edge so it is steady across the falling edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst || asleep)
    begin
      pixel_strobe_out <= 1'b0; // R7
      parallel_word_out <= `LSD_WORD_RESET; // R7
    end
    else
    begin
      pixel_strobe_out <= clk_s2; // R5
      if (buf_pop && buf_out_valid)
        parallel_word_out <= buf_out_data; // R4
    end
  end
endmodule : lsd_receiver
`default_nettype wire

// ===== test/lsd_receiver_monitor.sv
/*
  Port checker of the link receiver.
  Assumes four lanes and a 28-bit word; bound to lsd_receiver below.
*/
`timescale 1ns/1ns
`default_nettype none
module lsd_receiver_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link and control
  input wire logic [3:0] serial_lane_in,
  input wire logic link_clock_in,
  input wire logic sleep_n,
  input wire logic panel_ready,
  // Panel side
  input wire logic [27:0] parallel_word_out,
  input wire logic pixel_strobe_out,
  input wire logic link_locked,
  input wire logic word_overrun
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence asleep_s;
    !sleep_n [*4];
  endsequence
  strobe_follow_a: assert property (sleep_n && $past(sleep_n, 4) && !$past(rst, 4) |->
    pixel_strobe_out == $past(link_clock_in, 3)) else $error("strobe lag");
  sleep_zero_a: assert property (asleep_s |-> parallel_word_out == 28'h000_0000 && !link_locked)
    else $error("sleep output");
  sleep_entry_a: assert property ($fell(sleep_n) |-> ##[1:100] parallel_word_out == 28'h000_0000)
    else $error("sleep entry");
  word_hold_a: assert property (sleep_n && $past(sleep_n) && $changed(parallel_word_out) |->
    $rose(pixel_strobe_out)) else $error("word moved");
  stall_hold_a: assert property (!panel_ready && !$past(panel_ready) && sleep_n |->
    $stable(parallel_word_out)) else $error("stall moved");
  lock_bound_a: assert property (sleep_n && $rose(pixel_strobe_out) |->
    ##[0:60] (link_locked || !sleep_n)) else $error("no lock");
  lock_wake_a: assert property ($rose(link_locked) |-> $past(sleep_n, 8))
    else $error("early lock");
  overrun_pulse_a: assert property (word_overrun |=> !word_overrun [*5])
    else $error("overrun rate");
endmodule : lsd_receiver_monitor
bind lsd_receiver lsd_receiver_monitor i_lsd_receiver_monitor (.sys_clk, .rst, .serial_lane_in,
  .link_clock_in, .sleep_n, .panel_ready, .parallel_word_out, .pixel_strobe_out, .link_locked,
  .word_overrun);
`default_nettype wire

// ===== test/lsd_tx_model.sv
/*
  Serializer model: sends word n*STEP, seven bits per lane per 80 ns period.
  Assumes nothing of the receiver; its clock runs free, as a pixel clock does.
*/
`timescale 1ns/1ns
`default_nettype none
module lsd_tx_model #(
  parameter logic [27:0] STEP = 28'h093_a5c7
) (
  // Link
  output logic link_clock_in,
  output logic [3:0] serial_lane_in
);
  logic [27:0] word = 28'h000_0000;
  int slot[7] = '{11, 12, 11, 12, 11, 12, 11};
  initial
  begin
    link_clock_in = 1'b0;
    serial_lane_in = 4'h0;
    #3;
    forever
    begin
      word = word + STEP;
      for (int k = 0; k < 7; k++)
      begin
        link_clock_in = (k < 4);
        for (int l = 0; l < 4; l++)
          serial_lane_in[l] = word[l * 7 + k];
        #(slot[k]);
      end
    end
  end
endmodule : lsd_tx_model
`default_nettype wire

// ===== test/lsd_receiver_test.sv
/*
  Bench of the link receiver: the serializer model feeds the lanes, the bench drives sleep and stalls.
  Assumes words advance by STEP, so a gap shows a drop or a misplaced bit.
*/
`timescale 1ns/1ns
`default_nettype none
`define LSD_CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, got, exp); end end
module lsd_receiver_test;
  localparam logic [27:0] STEP = 28'h093_a5c7;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_n = 1'b1;
  logic panel_ready = 1'b1;
  logic link_clock_in;
  logic [3:0] serial_lane_in;
  logic [27:0] parallel_word_out;
  logic pixel_strobe_out;
  logic link_locked;
  logic word_overrun;
  logic [27:0] last_word = 28'h000_0000;
  logic [27:0] exp_word;
  int n_fail = 0;
  int n_compared = 0;
  int n_words = 0;
  int n_drops = 0;
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  lsd_tx_model i_lsd_tx_model (.link_clock_in, .serial_lane_in);
  lsd_receiver i_lsd_receiver (.sys_clk, .rst, .serial_lane_in, .link_clock_in, .sleep_n, .panel_ready,
    .parallel_word_out, .pixel_strobe_out, .link_locked, .word_overrun);
  always @(posedge sys_clk)
    if (word_overrun === 1'b1)
      n_drops++;
  // Sampled at the strobe's falling edge, where the word must be steady.
  always @(negedge pixel_strobe_out)
    if (!rst && sleep_n && parallel_word_out !== last_word)
    begin
      exp_word = last_word + STEP;
      if (parallel_word_out !== exp_word)
        exp_word = 28'(last_word + STEP * 28'(n_drops + 1));
      if (last_word !== 28'h000_0000)
        `LSD_CHECK(parallel_word_out, exp_word)
      if (parallel_word_out !== last_word + STEP)
        n_drops = 0;
      last_word = parallel_word_out;
      n_words++;
    end
  task automatic t_stream();
    int start;
    start = n_words;
    repeat (300) @(posedge sys_clk);
    `LSD_CHECK(link_locked, 1'b1)
    `LSD_CHECK(n_words - start > 15, 1'b1)
    $display("stream test done");
  endtask : t_stream
  task automatic t_stall();
    panel_ready <= 1'b0;
    repeat (80) @(posedge sys_clk);
    `LSD_CHECK(n_drops > 0, 1'b1)
    panel_ready <= 1'b1;
    repeat (200) @(posedge sys_clk);
    `LSD_CHECK(n_drops, 0)
    $display("stall test done");
  endtask : t_stall
  task automatic t_sleep();
    sleep_n <= 1'b0;
    repeat (100) @(posedge sys_clk);
    `LSD_CHECK(parallel_word_out, 28'h000_0000)
    `LSD_CHECK(link_locked, 1'b0)
    last_word = 28'h000_0000;
    n_drops = 0;
    sleep_n <= 1'b1;
    repeat (200) @(posedge sys_clk);
    `LSD_CHECK(link_locked, 1'b1)
    $display("sleep test done");
  endtask : t_sleep
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_stream();
    t_stall();
    t_sleep();
    wrap_up();
  end
  // The tests take about 9 us; more than twice that means a hang.
  initial
  begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule : lsd_receiver_test
`default_nettype wire
